// [src/burst_slave_counter.sv]
/*
 * Slave-side burst address counter.
 * Assumes the master strobes and burst flag are synchronous to clk_i.
 */
`default_nettype none
module burst_slave_counter #(
   parameter int ADDR_W = ext_bus_pkg::ADDR_W
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              strobe_i,
   input  wire logic              burst_i,
   input  wire logic              ack_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   output logic      [ADDR_W-1:0] addr_o,
   output logic                   active_o
);
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic              active_reg;
   logic              active_next;

   // Capture first address, then count completed transfers
   always_comb begin
      addr_next   = addr_reg;
      active_next = active_reg;
      if (strobe_i && ack_i) begin
         // Burst flag is low on the first word, high on the middle words, low on the last
         if (!active_reg && !burst_i) begin
            addr_next = addr_i + ADDR_W'(1);
         end else begin
            addr_next = addr_reg + ADDR_W'(1);
         end
         active_next = burst_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_reg   <= ext_bus_pkg::ADDR_RST;
         active_reg <= 1'b0;
      end else begin
         addr_reg   <= addr_next;
         active_reg <= active_next;
      end
   end

   // Bus address goes stale after the first word, so the counter takes over
   assign addr_o   = (active_reg || burst_i) ? addr_reg : addr_i;
   assign active_o = active_reg;

   a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (active_reg && strobe_i && ack_i) |=> addr_reg == $past(addr_reg) + ADDR_W'(1))
      else $error("burst counter did not step by one");
   a_hold_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (strobe_i && !ack_i) |=> $stable(addr_reg))
      else $error("burst counter moved during wait");
endmodule
`default_nettype wire

// [src/ext_bus_ctrl.sv]
/*
 * External parallel bus control: page crossing, burst flag, wait states,
 * suspend three-state, host bus request and grant.
 * Assumes a core access request port and synchronous pins on clk_i.
 */
// How it works
// - Flag page crossing to DRAM controller
// - Page flag only for bank 0
// - Only bus master drives page output
// - Master raises burst on consecutive addresses
// - Slave captures first address, counts internally
// - Host burst read keeps address incrementing
// - Burst high after first, low on last
// - Low acknowledge holds external access open
// - Drive acknowledge low for unready slave
// - Suspend low floats bus next cycle
// - Access under suspend stalls until release
// - Master releases bus, then grants host
// - Release floats address and page pins; strobes held high
// - Host request outranks peer requests
// - Grant held while host request stays
// - Ready low for async host with select
`default_nettype none
module ext_bus_ctrl #(
   parameter int ADDR_W = ext_bus_pkg::ADDR_W,
   parameter int PEER_N = ext_bus_pkg::PEER_N
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Core side
   input  wire logic                  core_req_i,
   input  wire logic                  core_wr_i,
   input  wire logic                  core_burst_i,
   input  wire logic                  core_last_i,
   input  wire logic [ADDR_W-1:0]     core_addr_i,
   input  wire logic [ext_bus_pkg::PAGE_SEL_W-1:0] page_size_i,
   input  wire logic                  int_mem_ready_i,
   input  wire logic                  is_master_i,
   output logic                       core_done_o,
   output logic                       core_stall_o,
   // Bus pins
   input  wire logic                  bus_suspend_tristate_n_i,
   input  wire logic                  host_bus_request_n_i,
   input  wire logic                  host_cs_n_i,
   input  wire logic [PEER_N-1:0]     peer_bus_requests_n_i,
   input  wire logic                  ack_i,
   input  wire logic                  read_strobes_n_i,
   input  wire logic                  write_strobes_n_i,
   input  wire logic                  sequential_burst_flag_i,
   input  wire logic                  sync_slave_i,
   input  wire logic [ADDR_W-1:0]     addr_i,
   output logic [ADDR_W-1:0]          addr_o,
   output logic                       addr_oe_o,
   output logic                       read_strobes_n_o,
   output logic                       write_strobes_n_o,
   output logic                       page_o,
   output logic                       page_oe_o,
   output logic                       sequential_burst_flag_o,
   output logic                       ack_o,
   output logic                       ack_oe_o,
   output logic                       host_bus_grant_n_o,
   output logic                       host_bus_grant_oe_o,
   output logic                       host_ready_out_n_o,
   output logic                       host_ready_out_oe_o,
   output logic [ADDR_W-1:0]          slave_addr_o,
   output logic                       peer_grant_o
);
   import ext_bus_pkg::*;

   // Elaboration checks on the parameters
   if (PEER_N < 1 || PEER_N > 6) begin : g_peer_chk
      $error("PEER_N out of range");
   end
   if (ADDR_W <= BANK_MSB) begin : g_addr_chk
      $error("ADDR_W too small");
   end

   ////////////////////////////////////////////////////////////////////////////
   // State and output registers
   bus_state_t        state_reg,  state_next;
   logic [ADDR_W-1:0] addr_reg,   addr_next;
   logic [ADDR_W-1:0] last_page_reg, last_page_next;
   logic              last_valid_reg, last_valid_next;
   logic              drive_reg,  drive_next;
   logic              rd_n_reg,   rd_n_next;
   logic              wr_n_reg,   wr_n_next;
   logic              page_reg,   page_next;
   logic              burst_reg,  burst_next;
   logic              grant_n_reg, grant_n_next;
   logic              grant_oe_reg, grant_oe_next;
   logic              ack_oe_reg, ack_oe_next;
   logic              host_ready_out_oe_reg, host_ready_out_oe_next;
   logic              done_reg,   done_next;
   logic              stall_reg,  stall_next;
   logic              peer_reg,   peer_next;
   logic              in_burst_reg, in_burst_next;

   logic              suspend;
   logic              host_req;
   logic              peer_req;
   logic [ADDR_W-1:0] page_mask;
   logic              slave_strobe;
   logic [ADDR_W-1:0] cnt_addr;

   assign suspend  = !bus_suspend_tristate_n_i;
   assign host_req = !host_bus_request_n_i;
   assign peer_req = !(&peer_bus_requests_n_i);
   assign page_mask = ~((ADDR_W'(1) << (PAGE_MIN_LOG2 + int'(page_size_i))) - ADDR_W'(1));
   assign slave_strobe = !read_strobes_n_i || !write_strobes_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // Slave burst counter for accesses into internal memory
   burst_slave_counter #(.ADDR_W(ADDR_W)) u_cnt (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .strobe_i (slave_strobe),
      .burst_i  (sequential_burst_flag_i),
      .ack_i    (int_mem_ready_i),
      .addr_i   (addr_i),
      .addr_o   (cnt_addr),
      .active_o ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      state_next      = state_reg;
      addr_next       = addr_reg;
      last_page_next  = last_page_reg;
      last_valid_next = last_valid_reg;
      drive_next      = drive_reg;
      rd_n_next       = 1'b1;
      wr_n_next       = 1'b1;
      page_next       = 1'b0;
      burst_next      = 1'b0;
      grant_n_next    = grant_n_reg;
      grant_oe_next   = grant_oe_reg;
      done_next       = 1'b0;
      stall_next      = 1'b0;
      peer_next       = 1'b0;
      in_burst_next   = in_burst_reg;
      // Wait states for a synchronous slave access not yet ready
      ack_oe_next     = slave_strobe && sync_slave_i && !int_mem_ready_i;
      // Async host wait while selected with request asserted
      host_ready_out_oe_next    = !host_cs_n_i && host_req && !int_mem_ready_i;
      case (state_reg)
         ST_IDLE: begin
            drive_next = is_master_i && !suspend;
            if (host_req) begin
               state_next    = ST_FLOAT;
               drive_next    = 1'b0;
               grant_oe_next = 1'b0;
            end else if (core_req_i && is_master_i) begin
               if (suspend) begin
                  stall_next = 1'b1;
               end else begin
                  state_next = ST_ACCESS;
                  addr_next  = core_addr_i;
                  drive_next = 1'b1;
                  rd_n_next  = core_wr_i;
                  wr_n_next  = !core_wr_i;
                  // Crossing when first access or new page in bank 0
                  page_next  = (core_addr_i[BANK_MSB:BANK_LSB] == BANK_DRAM) &&
                               (!last_valid_reg ||
                                ((core_addr_i & page_mask) != last_page_reg));
                  last_page_next  = core_addr_i & page_mask;
                  last_valid_next = 1'b1;
                  burst_next    = in_burst_reg && !core_last_i;
                  in_burst_next = core_burst_i && !core_last_i;
               end
            end else if (peer_req && !is_master_i) begin
               state_next = ST_PEER;
               drive_next = 1'b0;
            end
         end
         ST_ACCESS: begin
            rd_n_next  = rd_n_reg;
            wr_n_next  = wr_n_reg;
            page_next  = page_reg;
            burst_next = burst_reg;
            if (suspend) begin
               drive_next = 1'b0;
               stall_next = 1'b1;
            end else begin
               drive_next = 1'b1;
               if (ack_i) begin
                  done_next  = 1'b1;
                  rd_n_next  = 1'b1;
                  wr_n_next  = 1'b1;
                  page_next  = 1'b0;
                  burst_next = 1'b0;
                  state_next = ST_IDLE;
               end else begin
                  stall_next = 1'b1;
               end
            end
         end
         ST_FLOAT: begin
            drive_next = 1'b0;
            if (host_req) begin
               state_next    = ST_HOST;
               grant_n_next  = 1'b0;
               grant_oe_next = 1'b1;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_HOST: begin
            drive_next = 1'b0;
            if (!host_req) begin
               grant_n_next  = 1'b1;
               state_next    = ST_IDLE;
               in_burst_next = 1'b0;
            end
         end
         ST_PEER: begin
            drive_next = 1'b0;
            peer_next  = 1'b1;
            if (host_req) begin
               state_next = ST_FLOAT;
            end else if (!peer_req || is_master_i) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (suspend && state_reg != ST_ACCESS) begin
         drive_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg      <= ST_IDLE;
         addr_reg       <= ADDR_RST;
         last_page_reg  <= ADDR_RST;
         last_valid_reg <= 1'b0;
         drive_reg      <= 1'b0;
         rd_n_reg       <= 1'b1;
         wr_n_reg       <= 1'b1;
         page_reg       <= 1'b0;
         burst_reg      <= 1'b0;
         grant_n_reg    <= 1'b1;
         grant_oe_reg   <= 1'b0;
         ack_oe_reg     <= 1'b0;
         host_ready_out_oe_reg    <= 1'b0;
         done_reg       <= 1'b0;
         stall_reg      <= 1'b0;
         peer_reg       <= 1'b0;
         in_burst_reg   <= 1'b0;
      end else begin
         state_reg      <= state_next;
         addr_reg       <= addr_next;
         last_page_reg  <= last_page_next;
         last_valid_reg <= last_valid_next;
         drive_reg      <= drive_next;
         rd_n_reg       <= rd_n_next;
         wr_n_reg       <= wr_n_next;
         page_reg       <= page_next;
         burst_reg      <= burst_next;
         grant_n_reg    <= grant_n_next;
         grant_oe_reg   <= grant_oe_next;
         ack_oe_reg     <= ack_oe_next;
         host_ready_out_oe_reg    <= host_ready_out_oe_next;
         done_reg       <= done_next;
         stall_reg      <= stall_next;
         peer_reg       <= peer_next;
         in_burst_reg   <= in_burst_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter address registered for output
   logic [ADDR_W-1:0] slave_addr_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         slave_addr_reg <= ADDR_RST;
      end else begin
         slave_addr_reg <= cnt_addr;
      end
   end

   // Pin drivers, all from flip-flops or tied-low constants
   assign addr_o                  = addr_reg;
   assign addr_oe_o               = drive_reg;
   assign read_strobes_n_o        = rd_n_reg;
   assign write_strobes_n_o       = wr_n_reg;
   assign page_o                  = page_reg;
   assign page_oe_o               = drive_reg;
   assign sequential_burst_flag_o = burst_reg;
   assign ack_o                   = 1'b0;
   assign ack_oe_o                = ack_oe_reg;
   assign host_bus_grant_n_o      = grant_n_reg;
   assign host_bus_grant_oe_o     = grant_oe_reg;
   assign host_ready_out_n_o      = 1'b0;
   assign host_ready_out_oe_o     = host_ready_out_oe_reg;
   assign slave_addr_o            = slave_addr_reg;
   assign peer_grant_o            = peer_reg;
   assign core_done_o             = done_reg;
   assign core_stall_o            = stall_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_host_in;
      host_req && state_reg == ST_IDLE;
   endsequence
   a_suspend_float: assert property (@(posedge clk_i) disable iff (rst_i)
      suspend |=> !addr_oe_o)
      else $error("bus driven after suspend");
   a_page_bank: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(page_o) |-> addr_o[BANK_MSB:BANK_LSB] == BANK_DRAM)
      else $error("page flag outside bank 0");
   a_page_master: assert property (@(posedge clk_i) disable iff (rst_i)
      page_o |-> page_oe_o)
      else $error("page flag set while not driving");
   a_host_grant: assert property (@(posedge clk_i) disable iff (rst_i)
      s_host_in ##1 host_req |=> !host_bus_grant_n_o && !addr_oe_o)
      else $error("host not granted after float");
   a_grant_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!host_bus_grant_n_o && host_req) |=> !host_bus_grant_n_o)
      else $error("grant dropped while requested");
   a_grant_release: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_HOST && !host_req) |=> host_bus_grant_n_o)
      else $error("grant kept after release");
   a_host_priority: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_IDLE && host_req && peer_req) |=> state_reg == ST_FLOAT)
      else $error("peer won over host");
   a_ack_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_ACCESS && !ack_i) |=> !core_done_o)
      else $error("access done without ack");
   a_suspend_stall: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_ACCESS && suspend) |=> core_stall_o && !core_done_o)
      else $error("access completed under suspend");
   a_sync_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (slave_strobe && sync_slave_i && !int_mem_ready_i) |=> ack_oe_o && !ack_o)
      else $error("no wait state driven");
   a_host_ready_out_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (!host_cs_n_i && host_req && !int_mem_ready_i) |=> host_ready_out_oe_o)
      else $error("ready not pulled low");
   a_burst_last: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_IDLE && core_req_i && is_master_i && !suspend && !host_req
       && core_last_i) |=> !sequential_burst_flag_o)
      else $error("burst flag on last cycle");
endmodule
`default_nettype wire

// [src/ext_bus_pkg.sv]
/*
 * Constants shared by the external bus control block.
 * Assumes a single 40 MHz core clock; all pins sampled on it.
 */
`default_nettype none
package ext_bus_pkg;
   // Clock figures
   localparam int  CLK_PERIOD_NS   = 25;
   // Address and page layout
   localparam int  ADDR_W          = 32;
   localparam int  BANK_MSB        = 27;   // Bank number sits in address bits 27..26
   localparam int  BANK_LSB        = 26;
   localparam logic [1:0] BANK_DRAM = 2'h0; // Only bank 0 may hold DRAM
   localparam int  PAGE_SEL_W      = 3;    // Page size code width
   localparam int  PAGE_MIN_LOG2   = 8;    // Code 0 means 256-word pages
   localparam logic [PAGE_SEL_W-1:0] PAGE_SEL_RST = 3'h0;
   // Requester count on the peer arbitration lines
   localparam int  PEER_N          = 6;
   // Host grant settle: float one cycle before driving low
   localparam int  GRANT_FLOAT_CYC = 1;
   // Reset value of the counters
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

   // Bus ownership states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ACCESS  = 3'b001,
      ST_FLOAT   = 3'b010,
      ST_HOST    = 3'b011,
      ST_PEER    = 3'b100
   } bus_state_t;
endpackage
`default_nettype wire

// [tb/ext_bus_ctrl_tb_top.sv]
/*
 * Self-checking bench for the external bus control block.
 * Assumes a 40 MHz clock; inputs change by non-blocking assignment at the
 * rising edge; acknowledge is pulled up when neither party drives it.
 */
`default_nettype none
module ext_bus_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, core_req_i = 1'b0, core_wr_i = 1'b0;
   logic        core_burst_i = 1'b0, core_last_i = 1'b0, int_mem_ready_i = 1'b1;
   logic        is_master_i = 1'b1, bus_suspend_tristate_n_i = 1'b1, host_cs_n_i = 1'b1;
   logic        host_bus_request_n_i = 1'b1, read_strobes_n_i = 1'b1, sync_slave_i = 1'b0;
   logic        write_strobes_n_i = 1'b1, sequential_burst_flag_i = 1'b0;
   logic [31:0] core_addr_i = 32'h0, addr_i = 32'h0;
   logic [2:0]  page_size_i = 3'h0;
   logic [5:0]  peer_bus_requests_n_i = 6'h3f;
   logic [3:0]  waits = 4'h0;
   int          fails = 0, n_compared = 0;
   wire logic [31:0] addr_o, slave_addr_o;
   wire logic   ack_i, mem_oe, mem_ack, core_done_o, core_stall_o, addr_oe_o, page_o;
   wire logic   read_strobes_n_o, write_strobes_n_o, page_oe_o, sequential_burst_flag_o;
   wire logic   ack_o, ack_oe_o, host_bus_grant_n_o, host_bus_grant_oe_o, peer_grant_o;
   wire logic   host_ready_out_n_o, host_ready_out_oe_o;
   ////////////////////////////////////////////////////////////////////////////
   // Clock, acknowledge wire with its pull-up, design and memory model
   always #12.5 clk_i = ~clk_i;
   assign ack_i = ack_oe_o ? ack_o : (mem_oe ? mem_ack : 1'b1);
   ext_bus_ctrl ext_bus_ctrl_i (.clk_i, .rst_i, .core_req_i, .core_wr_i, .core_burst_i,
      .core_last_i, .core_addr_i, .page_size_i, .int_mem_ready_i, .is_master_i,
      .core_done_o, .core_stall_o, .bus_suspend_tristate_n_i, .host_bus_request_n_i,
      .host_cs_n_i, .peer_bus_requests_n_i, .ack_i, .read_strobes_n_i, .write_strobes_n_i,
      .sequential_burst_flag_i, .sync_slave_i, .addr_i, .addr_o, .addr_oe_o,
      .read_strobes_n_o, .write_strobes_n_o, .page_o, .page_oe_o, .sequential_burst_flag_o,
      .ack_o, .ack_oe_o, .host_bus_grant_n_o, .host_bus_grant_oe_o, .host_ready_out_n_o,
      .host_ready_out_oe_o, .slave_addr_o, .peer_grant_o);
   ext_mem_responder ext_mem_responder_i (.clk_i, .rst_i, .rd_n_i(read_strobes_n_o),
      .wr_n_i(write_strobes_n_o), .drive_i(addr_oe_o), .waits_i(waits),
      .ack_oe_o(mem_oe), .ack_o(mem_ack));
   ////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [31:0] got, exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // Print counts and verdict, then stop
   task automatic end_of_test;
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One core access; returns page and burst flags seen and strobe-low cycles
   task automatic access(input logic [31:0] a, input logic b, l,
                         output logic pg, bf, output int ns);
      int n;
      logic lo;
      logic [31:0] ad;
      n = 0;
      ns = 0;
      ad = 32'h0;
      @(posedge clk_i);
      core_req_i <= 1'b1;
      core_addr_i <= a;
      core_burst_i <= b;
      core_last_i <= l;
      // Values read at an edge are those the design samples there
      do begin
         @(posedge clk_i);
         n++;
         lo = (read_strobes_n_o & write_strobes_n_o) === 1'b0;
         if (lo) begin
            ns++;
            pg = page_o;
            bf = sequential_burst_flag_o;
            ad = addr_o;
         end
      end while (!(lo && ack_i === 1'b1) && n < 50);
      // Drop the request at the completing edge so it is not taken twice
      core_req_i <= 1'b0;
      core_burst_i <= 1'b0;
      core_last_i <= 1'b0;
      @(posedge clk_i);
      chk(core_done_o, 1'b1, "no done after acknowledge");
      chk(ad, a, "address not on bus");
      chk(n < 50, 1'b1, "access never completed");
   endtask
   // Strobe stretched by exactly the wait states, read and write
   task automatic t_waits;
      logic pg, bf;
      int ns;
      waits <= 4'h3;
      access(32'h0000_0040, 1'b0, 1'b0, pg, bf, ns);
      chk(ns, 4, "strobe length with three waits");
      waits <= 4'h0;
      core_wr_i <= 1'b1;
      access(32'h0000_0041, 1'b0, 1'b0, pg, bf, ns);
      chk(ns, 1, "strobe length with no waits");
      core_wr_i <= 1'b0;
   endtask
   // Page boundary flag across sizes and banks
   task automatic t_page;
      logic pg, bf;
      int ns;
      logic [31:0] ad [8] = '{32'h0000_00ff, 32'h0000_0100, 32'h0000_0101, 32'h0400_0200,
                              32'h0400_0300, 32'h0000_0000, 32'h0000_0100, 32'h0000_0200};
      logic [7:0] ck = 8'b1111_1111;
      logic [7:0] ex = 8'b1010_0010;
      for (int i = 0; i < 8; i++) begin
         page_size_i <= (i < 5) ? 3'h0 : 3'h1;
         access(ad[i], 1'b0, 1'b0, pg, bf, ns);
         if (ck[i]) chk(pg, ex[i], "page flag");
      end
   endtask
   // Three-word burst: flag low, high, low
   task automatic t_burst;
      logic pg, bf;
      int ns;
      logic [2:0] fe = 3'b010;
      for (int i = 0; i < 3; i++) begin
         access(32'h0000_0020 + i, 1'b1, i == 2, pg, bf, ns);
         chk(bf, fe[i], "burst flag");
      end
   endtask
   // A non-master leaves the page pin and read strobe alone
   task automatic t_master;
      logic pg, bf;
      int ns;
      @(posedge clk_i);
      is_master_i <= 1'b0;
      core_req_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk(page_oe_o, 1'b0, "page pin driven by non-master");
      chk(read_strobes_n_o, 1'b1, "strobe from non-master");
      @(posedge clk_i);
      is_master_i <= 1'b1;
      core_req_i <= 1'b0;
      access(32'h0000_0030, 1'b0, 1'b0, pg, bf, ns);
   endtask
   // Suspend floats the bus and stalls a pending access until released
   task automatic t_suspend;
      logic pg, bf;
      int ns;
      @(posedge clk_i);
      bus_suspend_tristate_n_i <= 1'b0;
      core_req_i <= 1'b1;
      core_addr_i <= 32'h0000_0080;
      repeat (4) @(posedge clk_i);
      #1;
      chk(addr_oe_o, 1'b0, "bus driven under suspend");
      chk(core_stall_o, 1'b1, "no stall under suspend");
      chk(core_done_o, 1'b0, "completed under suspend");
      @(posedge clk_i);
      bus_suspend_tristate_n_i <= 1'b1;
      access(32'h0000_0080, 1'b0, 1'b0, pg, bf, ns);
      chk(ns, 1, "access after release");
   endtask
   // Host request beats peers, floats then grants, held until withdrawn
   task automatic t_host;
      @(posedge clk_i);
      host_bus_request_n_i <= 1'b0;
      peer_bus_requests_n_i <= 6'h00;
      host_cs_n_i <= 1'b0;
      int_mem_ready_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk(host_bus_grant_oe_o, 1'b0, "grant not floated first");
      chk(host_bus_grant_n_o, 1'b1, "grant before float cycle");
      chk(addr_oe_o, 1'b0, "address driven in float cycle");
      @(posedge clk_i);
      #1;
      chk(host_bus_grant_n_o, 1'b0, "grant missing");
      chk(host_bus_grant_oe_o, 1'b1, "grant not driven");
      chk(addr_oe_o, 1'b0, "address still driven");
      chk(peer_grant_o, 1'b0, "peer won over host");
      chk(host_ready_out_oe_o, 1'b1, "no host wait state");
      chk(host_ready_out_n_o, 1'b0, "host ready not low");
      repeat (5) @(posedge clk_i);
      #1;
      chk(host_bus_grant_n_o, 1'b0, "grant dropped early");
      @(posedge clk_i);
      host_bus_request_n_i <= 1'b1;
      host_cs_n_i <= 1'b1;
      int_mem_ready_i <= 1'b1;
      peer_bus_requests_n_i <= 6'h3f;
      repeat (2) @(posedge clk_i);
      #1;
      chk(host_bus_grant_n_o, 1'b1, "grant kept after release");
   endtask
   // Slave burst read: wait states, then internal counting
   task automatic t_slave;
      @(posedge clk_i);
      is_master_i <= 1'b0;
      sync_slave_i <= 1'b1;
      int_mem_ready_i <= 1'b0;
      read_strobes_n_i <= 1'b0;
      addr_i <= 32'h0000_0300;
      repeat (3) @(posedge clk_i);
      #1;
      chk(ack_oe_o, 1'b1, "no slave wait state");
      chk(ack_o, 1'b0, "acknowledge not low");
      @(posedge clk_i);
      int_mem_ready_i <= 1'b1;
      // First word completes at the next edge; the bus address then goes stale
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         sequential_burst_flag_i <= (i < 2);
         read_strobes_n_i <= (i == 3);
         addr_i <= 32'hffff_fcff;
         #1;
         chk(slave_addr_o, 32'h0000_0300 + i, "burst counter address");
      end
      chk(ack_oe_o, 1'b0, "wait state kept after ready");
      is_master_i <= 1'b1;
      sync_slave_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_waits();
      t_page();
      t_burst();
      t_master();
      t_suspend();
      t_host();
      t_slave();
      end_of_test();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire

// [tb/ext_mem_responder.sv]
/*
 * Memory-side responder on the external bus: stretches each strobed
 * access by a set number of wait states on the acknowledge line.
 * Assumes the bus master changes its strobes just after clk_i rises,
 * and that a pull-up holds acknowledge high whenever nobody drives it.
 */
`default_nettype none
module ext_mem_responder (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic       drive_i,
   input  wire logic [3:0] waits_i,
   output logic            ack_oe_o,
   output logic            ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;
   logic [3:0] wait_next;
   logic       sel;
   ////////////////////////////////////////////////////////////////////////////
   // Selected only while the master drives the bus with a strobe low
   assign sel      = drive_i && !(rd_n_i && wr_n_i);
   // Acknowledge driven low until the wait count runs out, then high; released when not selected
   assign ack_oe_o = sel;
   assign ack_o    = (wait_reg >= waits_i);
   // Wait counter, cleared between accesses until it saturates at 15, then held
   always_comb begin
      wait_next = sel ? wait_reg + 4'h1 : 4'h0;
      if (wait_reg == 4'hf) begin
         wait_next = wait_reg;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_reg <= 4'h0;
      end else begin
         wait_reg <= wait_next;
      end
   end
endmodule
`default_nettype wire
